// *** design/cmp_ctrl.sv ***
// comparator control: input selection, output sync, event detect, irq, apb
// assumes the analog core sits outside and follows the select outputs;
// the cpu core provides the global irq enable and the vector acknowledge
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Contract
// - synchronise comparator result, 2 cycle delay
// - mux on, converter off: channel code 0-7 picks input, higher codes use pin
// - mux off or converter on: negative pin used
// - bandgap select chooses reference or positive pin
// - power-off bit switches comparator off, writable anytime
// - mode 00 toggle, 01 reserved, 10 fall, 11 rise
// - hardware sets flag on matching event
// - flag cleared by vector or writing one
// - request needs flag, enable and global enable
// - capture route feeds comparator to timer capture
// - buffer disable bit gates pin read to zero
module cmp_ctrl
  import cmp_pkg::*;
(
  input wire logic i_core_clk, // system clock, 125 MHz
  input wire logic i_rstn, // async reset, active low
  input wire logic i_ce, // clock enable
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped address
  input wire logic i_cmp_raw, // raw comparator result, async
  input wire logic i_pos_pin_dig, // positive pin digital level, async
  input wire logic i_neg_pin_dig, // negative pin digital level, async
  input wire logic i_global_irq_en, // core global irq enable
  input wire logic i_vector_ack, // comparator vector executed, pulse
  output logic o_cmp_power_off, // comparator power switched off
  output logic o_bandgap_select, // positive input from bandgap
  output logic o_neg_sel_pin, // negative input from pin
  output logic [2:0] o_neg_channel, // analog channel when not pin
  output logic o_capture_route_en, // capture front end fed by comparator
  output logic o_capture_in, // comparator level to capture logic
  output logic [7:0] o_dig_buf_disable, // digital buffer disables
  output logic [1:0] o_pin_read, // pin input register bits
  output logic o_cmp_irq_req, // comparator irq request to core
  output logic o_irq // system irq, sticky status gated by the mask
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised inputs

  logic [SYNC_W-1:0] sync_s; // bit0 comparator, bit1 pos pin, bit2 neg pin
  logic cmp_out; // synchronised comparator output

  // one synchroniser for the comparator and both pin levels
  cmp_sync #(
    .W(SYNC_W)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_async({i_neg_pin_dig, i_pos_pin_dig, i_cmp_raw}),
    .o_sync(sync_s)
  );

  assign cmp_out = sync_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic bus_done; // access phase completing this cycle
  logic wr_en; // write takes effect
  logic wr_csr; // write to control/status
  logic wr_dis; // write to buffer disables
  logic wr_muxc; // write to mux control
  logic wr_convb; // write to converter control b
  logic wr_stat; // write to sticky status
  logic wr_mask; // write to mask
  logic cap_r; // read data captured for this transfer
  logic cap_nxt;

  // ready only once read data has been registered; zero waits while ce high
  assign o_pready = i_ce & cap_r;
  assign bus_done = i_psel & i_penable & o_pready;
  assign wr_en = bus_done & i_pwrite;
  assign wr_csr = wr_en & (i_paddr == ADDR_CSR);
  assign wr_dis = wr_en & (i_paddr == ADDR_DIG_DIS);
  assign wr_muxc = wr_en & (i_paddr == ADDR_MUX_CTRL);
  assign wr_convb = wr_en & (i_paddr == ADDR_CONV_B);
  assign wr_stat = wr_en & (i_paddr == ADDR_IRQ_STAT);
  assign wr_mask = wr_en & (i_paddr == ADDR_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // control state

  logic [7:0] dis_r, dis_nxt; // digital buffer disables
  logic pwr_off_r, pwr_off_nxt; // comparator power off
  logic bandgap_r, bandgap_nxt; // bandgap on positive input
  logic flag_r, flag_nxt; // comparator event flag
  logic ie_r, ie_nxt; // comparator irq enable
  logic route_r, route_nxt; // capture route enable
  evt_mode_t mode_r, mode_nxt; // event mode select
  logic mux_en_r, mux_en_nxt; // negative input mux enable
  logic conv_en_r, conv_en_nxt; // converter enable
  logic [4:0] chan_r, chan_nxt; // channel select code
  logic tog_r, tog_nxt; // sticky any-toggle status
  logic [STAT_W-1:0] mask_r, mask_nxt; // status mask
  logic prev_r, prev_nxt; // comparator output last cycle
  logic rise; // rising output edge
  logic fall; // falling output edge
  logic hit; // event matching the mode
  logic flag_clr; // any clear source for the flag
  logic tog_clr; // clear for toggle status

  // edge detect against the previous synchronised sample
  assign rise = cmp_out & ~prev_r;
  assign fall = ~cmp_out & prev_r;

  // next values for all control state; an event beats a clear
  always_comb begin
    dis_nxt = dis_r;
    pwr_off_nxt = pwr_off_r;
    bandgap_nxt = bandgap_r;
    ie_nxt = ie_r;
    route_nxt = route_r;
    mode_nxt = mode_r;
    mux_en_nxt = mux_en_r;
    conv_en_nxt = conv_en_r;
    chan_nxt = chan_r;
    mask_nxt = mask_r;
    prev_nxt = cmp_out;
    // event select; the reserved code never fires
    case (mode_r)
      MODE_TOGGLE: hit = rise | fall;
      MODE_FALL: hit = fall;
      MODE_RISE: hit = rise;
      default: hit = 1'b0;
    endcase
    // writing one clears, writing zero leaves the flag alone
    flag_clr = i_vector_ack
             | (wr_csr & i_pwdata[CSR_FLAG])
             | (wr_stat & i_pwdata[STAT_EVENT]);
    tog_clr = wr_stat & i_pwdata[STAT_TOGGLE];
    flag_nxt = hit | (flag_r & ~flag_clr);
    tog_nxt = rise | fall | (tog_r & ~tog_clr);
    if (wr_csr) begin
      // power off is accepted at any time, no interlock
      pwr_off_nxt = i_pwdata[CSR_PWR_OFF];
      bandgap_nxt = i_pwdata[CSR_BANDGAP];
      ie_nxt = i_pwdata[CSR_IRQ_EN];
      route_nxt = i_pwdata[CSR_ROUTE];
      mode_nxt = evt_mode_t'(i_pwdata[CSR_MODE_HI:CSR_MODE_LO]);
    end
    if (wr_dis) begin
      dis_nxt = i_pwdata[7:0];
    end
    if (wr_muxc) begin
      conv_en_nxt = i_pwdata[MUXC_CONV_EN];
      chan_nxt = i_pwdata[MUXC_CHAN_W-1:0];
    end
    if (wr_convb) begin
      mux_en_nxt = i_pwdata[CONVB_MUX_EN];
    end
    if (wr_mask) begin
      mask_nxt = i_pwdata[STAT_W-1:0];
    end
  end

  // register control state
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dis_r <= RST_DIG_DIS;
      pwr_off_r <= 1'b0;
      bandgap_r <= 1'b0;
      flag_r <= 1'b0;
      ie_r <= 1'b0;
      route_r <= 1'b0;
      mode_r <= MODE_TOGGLE;
      mux_en_r <= 1'b0;
      conv_en_r <= 1'b0;
      chan_r <= RST_CHAN;
      tog_r <= 1'b0;
      mask_r <= RST_MASK;
      prev_r <= 1'b0;
    end else if (i_ce) begin
      dis_r <= dis_nxt;
      pwr_off_r <= pwr_off_nxt;
      bandgap_r <= bandgap_nxt;
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      route_r <= route_nxt;
      mode_r <= mode_nxt;
      mux_en_r <= mux_en_nxt;
      conv_en_r <= conv_en_nxt;
      chan_r <= chan_nxt;
      tog_r <= tog_nxt;
      mask_r <= mask_nxt;
      prev_r <= prev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs toward the analog core, timer and cpu

  logic neg_pin_nxt; // negative input from pin
  logic [2:0] neg_chan_nxt; // analog channel
  logic cap_in_nxt; // capture feed
  logic irq_req_nxt; // comparator irq request
  logic irq_nxt; // system irq level
  logic [1:0] pin_read_nxt; // gated pin reads
  logic [STAT_W-1:0] stat; // sticky status view

  assign stat = {tog_r, flag_r};

  // pin reads forced low while the buffer is off
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      assign pin_read_nxt[gi] = sync_s[gi+1] & ~dis_r[gi];
    end
  endgenerate

  // input selection; codes above the last channel fall back to the pin
  always_comb begin
    neg_pin_nxt = 1'b1;
    neg_chan_nxt = 3'h0;
    if (mux_en_r && !conv_en_r && (chan_r <= CHAN_LAST)) begin
      neg_pin_nxt = 1'b0;
      neg_chan_nxt = chan_r[2:0];
    end
    // with the route off the capture input sits low, not floating
    cap_in_nxt = route_r & cmp_out;
    irq_req_nxt = flag_r & ie_r & i_global_irq_en;
    irq_nxt = |(stat & mask_r);
  end

  // register outputs
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_neg_sel_pin <= 1'b1;
      o_neg_channel <= 3'h0;
      o_capture_in <= 1'b0;
      o_cmp_irq_req <= 1'b0;
      o_irq <= 1'b0;
      o_pin_read <= 2'h0;
    end else if (i_ce) begin
      o_neg_sel_pin <= neg_pin_nxt;
      o_neg_channel <= neg_chan_nxt;
      o_capture_in <= cap_in_nxt;
      o_cmp_irq_req <= irq_req_nxt;
      o_irq <= irq_nxt;
      o_pin_read <= pin_read_nxt;
    end
  end

  // these are flops already, passed straight out
  assign o_cmp_power_off = pwr_off_r;
  assign o_bandgap_select = bandgap_r;
  assign o_capture_route_en = route_r;
  assign o_dig_buf_disable = dis_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb read path

  logic [7:0] rd_byte; // selected register
  logic rd_err; // unmapped address
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;

  // read data is sampled every enabled cycle, so it lags by one clock
  always_comb begin
    rd_err = 1'b0;
    case (i_paddr)
      ADDR_CSR: rd_byte = {pwr_off_r, bandgap_r, cmp_out, flag_r, ie_r, route_r, mode_r};
      ADDR_DIG_DIS: rd_byte = dis_r;
      ADDR_MUX_CTRL: rd_byte = {conv_en_r, 2'h0, chan_r};
      ADDR_CONV_B: rd_byte = {1'b0, mux_en_r, 6'h00};
      ADDR_IRQ_STAT: rd_byte = {6'h00, stat};
      ADDR_IRQ_MASK: rd_byte = {6'h00, mask_r};
      default: begin
        rd_byte = 8'h00;
        rd_err = 1'b1;
      end
    endcase
    prdata_nxt = {24'h000000, rd_byte};
    pslverr_nxt = rd_err;
    cap_nxt = i_psel & ~bus_done;
  end

  // register the read answer
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
      cap_r <= 1'b0;
    end else if (i_ce) begin
      o_prdata <= prdata_nxt;
      o_pslverr <= pslverr_nxt;
      cap_r <= cap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  a_sync_delay: assert property (
    $past(i_rstn) && $past(i_rstn, 2) && $past(i_ce) && $past(i_ce, 2) |-> cmp_out == $past(i_cmp_raw, 2))
    else $error("comparator output not two cycles behind raw");

  a_chan_pick: assert property (
    i_ce && mux_en_r && !conv_en_r && chan_r <= CHAN_LAST
    |=> !o_neg_sel_pin && o_neg_channel == $past(chan_r[2:0]))
    else $error("channel not selected as negative input");

  a_pin_pick: assert property (
    i_ce && (!mux_en_r || conv_en_r) |=> o_neg_sel_pin)
    else $error("negative pin not selected");

  a_power_write: assert property (
    i_ce && wr_csr |=> o_cmp_power_off == $past(i_pwdata[CSR_PWR_OFF]))
    else $error("power-off bit did not take the write");

  a_rise_sets: assert property (
    i_ce && mode_r == MODE_RISE && rise |=> flag_r)
    else $error("rising edge did not set the flag");

  a_rsvd_quiet: assert property (
    i_ce && mode_r == MODE_RSVD && !flag_r |=> !flag_r)
    else $error("reserved mode set the flag");

  a_flag_w1c: assert property (
    i_ce && wr_csr && i_pwdata[CSR_FLAG] && !hit |=> !flag_r)
    else $error("writing one did not clear the flag");

  a_flag_w0: assert property (
    i_ce && flag_r && !flag_clr |=> flag_r)
    else $error("flag lost without a clear");

  a_irq_gate: assert property (
    i_ce |=> o_cmp_irq_req == ($past(flag_r) && $past(ie_r) && $past(i_global_irq_en)))
    else $error("irq request does not follow its enables");

  a_irq_block: assert property (
    i_ce && !ie_r |=> !o_cmp_irq_req)
    else $error("irq request raised with enable clear");

  a_capture_feed: assert property (
    i_ce |=> o_capture_in == ($past(route_r) && $past(cmp_out)))
    else $error("capture input does not follow route");

  a_pin_gated: assert property (
    i_ce && dis_r[0] |=> !o_pin_read[0])
    else $error("disabled positive pin read not zero");

  a_pin_gated_hi: assert property (
    i_ce && dis_r[1] |=> !o_pin_read[1])
    else $error("disabled negative pin read not zero");

endmodule // cmp_ctrl

// *** design/cmp_pkg.sv ***
// comparator control: register map, field positions, reset values, modes
// assumes an APB slave with 32-bit data, one aligned word per register
package cmp_pkg;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_DIG_DIS = 6'h01; // digital_input_disable
  localparam logic [5:0] IDX_MUX_CTRL = 6'h02; // converter enable and channel
  localparam logic [5:0] IDX_CONV_B = 6'h03; // converter_control_b
  localparam logic [5:0] IDX_IRQ_STAT = 6'h04; // sticky event status
  localparam logic [5:0] IDX_IRQ_MASK = 6'h05; // mask for the system line
  localparam logic [5:0] IDX_CSR = 6'h08; // comparator_control_status

  localparam logic [7:0] ADDR_DIG_DIS = {IDX_DIG_DIS, 2'h0};
  localparam logic [7:0] ADDR_MUX_CTRL = {IDX_MUX_CTRL, 2'h0};
  localparam logic [7:0] ADDR_CONV_B = {IDX_CONV_B, 2'h0};
  localparam logic [7:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'h0};
  localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
  localparam logic [7:0] ADDR_CSR = {IDX_CSR, 2'h0};

  // comparator_control_status fields
  localparam int CSR_PWR_OFF = 7;
  localparam int CSR_BANDGAP = 6;
  localparam int CSR_OUTPUT = 5;
  localparam int CSR_FLAG = 4;
  localparam int CSR_IRQ_EN = 3;
  localparam int CSR_ROUTE = 2;
  localparam int CSR_MODE_HI = 1;
  localparam int CSR_MODE_LO = 0;

  // converter_control_b field
  localparam int CONVB_MUX_EN = 6;

  // mux control fields: channel code in the low bits, enable on top
  localparam int MUXC_CONV_EN = 7;
  localparam int MUXC_CHAN_W = 5;
  localparam logic [4:0] CHAN_LAST = 5'h07; // highest code mapped to a channel

  // sticky status / mask fields
  localparam int STAT_EVENT = 0;
  localparam int STAT_TOGGLE = 1;
  localparam int STAT_W = 2;

  // reset values
  localparam logic [7:0] RST_DIG_DIS = 8'h00;
  localparam logic [4:0] RST_CHAN = 5'h00;
  localparam logic [1:0] RST_MASK = 2'h0;

  // number of synchronised inputs: comparator and both pin levels
  localparam int SYNC_W = 3;

  // event mode select encodings
  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'h0,
    MODE_RSVD = 2'h1,
    MODE_FALL = 2'h2,
    MODE_RISE = 2'h3
  } evt_mode_t;

endpackage

// *** design/cmp_sync.sv ***
// two-flop synchroniser for levels arriving from outside the clock domain
// assumes each bit is an independent level; no bus coherence is kept
`timescale 1ns/1ns
module cmp_sync #(
  parameter int W = 1
) (
  input wire logic i_core_clk, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic [W-1:0] i_async, // asynchronous levels
  output logic [W-1:0] o_sync // synchronised levels
);

  logic [W-1:0] meta_r; // first stage, read only by the second
  logic [W-1:0] sync_r; // second stage, safe to use

  // both stages shift together; the first is never looked at elsewhere
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (i_ce) begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule // cmp_sync

// *** verification/cmp_analog_model.sv ***
// analog side model: comparator core and its input multiplexers
// assumes the bench drives pin and channel levels in millivolts
`timescale 1ns/1ns
module cmp_analog_model #(
  parameter logic [11:0] BANDGAP_MV = 12'h44C // reference level, plain default
) (
  input wire logic i_power_off, // core unpowered
  input wire logic i_bandgap_select, // reference on positive side
  input wire logic i_neg_sel_pin, // negative pin selected
  input wire logic [2:0] i_neg_channel, // channel on negative side
  input wire logic [11:0] i_pos_mv, // positive pin level
  input wire logic [11:0] i_neg_mv, // negative pin level
  input wire logic [7:0][11:0] i_chan_mv, // analog channel levels
  output logic o_cmp_raw // raw comparator result
);
  logic [11:0] pos_v; // positive side level
  logic [11:0] neg_v; // negative side level
  ////////////////////////////////////////
  // routing and compare, settles at once like the real core
  always_comb begin
    pos_v = i_bandgap_select ? BANDGAP_MV : i_pos_mv;
    neg_v = i_neg_sel_pin ? i_neg_mv : i_chan_mv[i_neg_channel];
    // an unpowered core gives no valid answer; park it low
    o_cmp_raw = i_power_off ? 1'b0 : (pos_v > neg_v);
  end
endmodule // cmp_analog_model

// *** verification/testbench.sv ***
// bench: apb master, queued read checks, analog stimulus
// assumes zero or more wait states, i_ce held high except for one drop near the end
`timescale 1ns/1ns
module testbench;
  import cmp_pkg::*;
  typedef struct packed {logic rd; logic [31:0] d; logic e;} exp_t;
  logic core_clk = 1'b0; // system clock
  logic rstn = 1'b0; // reset, active low
  logic ce = 1'b1; // clock enable, dropped once to freeze the block
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb enable
  logic pwrite = 1'b0; // apb direction
  logic [7:0] paddr = 8'h00; // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready, pslverr, cmp_raw, pwr_off, bg_sel, neg_pin, route_en, cap_in, irq_req, irq;
  logic pos_dig = 1'b1, neg_dig = 1'b1, gie = 1'b0, vack = 1'b0; // core side inputs
  logic [2:0] neg_ch; // selected channel
  logic [7:0] dis; // buffer disables
  logic [1:0] pin_rd; // pin read bits
  logic [11:0] pos_mv = 12'h064, neg_mv = 12'h0C8; // pin levels
  logic [7:0][11:0] chan_mv = '0; // channel levels
  logic [31:0] seed = 32'h00000042; // xorshift state
  logic [31:0] v; // random word
  int mismatches = 0;
  int check_count = 0;
  exp_t expq[$]; // expected apb answers
  exp_t cur; // oldest note
  always #4 core_clk = ~core_clk;
  cmp_ctrl cmp_ctrl_inst (.i_core_clk(core_clk), .i_rstn(rstn), .i_ce(ce), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_cmp_raw(cmp_raw), .i_pos_pin_dig(pos_dig),
    .i_neg_pin_dig(neg_dig), .i_global_irq_en(gie), .i_vector_ack(vack), .o_cmp_power_off(pwr_off),
    .o_bandgap_select(bg_sel), .o_neg_sel_pin(neg_pin), .o_neg_channel(neg_ch),
    .o_capture_route_en(route_en), .o_capture_in(cap_in), .o_dig_buf_disable(dis),
    .o_pin_read(pin_rd), .o_cmp_irq_req(irq_req), .o_irq(irq));
  cmp_analog_model cmp_analog_model_inst (.i_power_off(pwr_off), .i_bandgap_select(bg_sel),
    .i_neg_sel_pin(neg_pin), .i_neg_channel(neg_ch), .i_pos_mv(pos_mv), .i_neg_mv(neg_mv),
    .i_chan_mv(chan_mv), .o_cmp_raw(cmp_raw));
  ////////////////////////////////////////
  // verdict, reached from the main flow or a timeout
  task summarize();
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task idle(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // one transfer; starts after an edge so psel never toggles twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
    int n;
    @(posedge core_clk);
    expq.push_back('{~w, e, er});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask
  ////////////////////////////////////////
  // answer watcher: sees pre-edge values at the completing edge
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (expq.size() == 0) begin
        mismatches++;
        $display("unexpected apb answer expected none seen %h", prdata);
      end else begin
        cur = expq.pop_front();
        if (cur.rd) chk("prdata", cur.d, prdata);
        chk("pslverr", {31'h0, cur.e}, {31'h0, pslverr});
      end
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  ////////////////////////////////////////
  initial begin
    idle(6);
    rstn <= 1'b1;
    chk("neg_pin", 1, neg_pin);
    rd(ADDR_DIG_DIS, 0);
    rd(ADDR_CONV_B, 0);
    rd(ADDR_CSR, 0);
    apb(1'b0, 8'hFC, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'hFC, 32'hFF, 32'h0, 1'b1);
    // negative side mux: every channel code plus the first unmapped one
    wr(ADDR_CONV_B, 32'h40);
    for (int c = 0; c < 9; c++) begin
      wr(ADDR_MUX_CTRL, c);
      idle(2);
      chk("neg_pin", c > 7, neg_pin);
      if (c < 8) chk("neg_ch", c, neg_ch);
    end
    wr(ADDR_MUX_CTRL, 32'h83);
    idle(2);
    chk("neg_pin", 1, neg_pin);
    wr(ADDR_MUX_CTRL, 32'h03);
    wr(ADDR_CONV_B, 0);
    idle(2);
    chk("neg_pin", 1, neg_pin);
    // event modes: rise then fall, irq kept off while mode changes
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CSR, 32'h10 | m);
      wr(ADDR_IRQ_STAT, 32'h3);
      pos_mv <= 12'h12C;
      idle(5);
      rd(ADDR_CSR, 32'h20 | m | ((m == 0 || m == 3) ? 32'h10 : 0));
      rd(ADDR_IRQ_STAT, 32'h2 | ((m == 0 || m == 3) ? 32'h1 : 0));
      wr(ADDR_CSR, 32'h10 | m);
      pos_mv <= 12'h064;
      idle(5);
      rd(ADDR_CSR, m | ((m == 0 || m == 2) ? 32'h10 : 0));
    end
    // request needs flag, enable and global enable
    wr(ADDR_CSR, 32'h13);
    wr(ADDR_CSR, 32'h0B);
    pos_mv <= 12'h12C;
    idle(6);
    chk("irq_req", 0, irq_req);
    gie <= 1'b1;
    idle(3);
    chk("irq_req", 1, irq_req);
    vack <= 1'b1;
    @(posedge core_clk);
    vack <= 1'b0;
    idle(3);
    chk("irq_req", 0, irq_req);
    rd(ADDR_CSR, 32'h2B);
    wr(ADDR_CSR, 32'h03);
    wr(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_IRQ_MASK, 32'h1);
    pos_mv <= 12'h064;
    idle(5);
    pos_mv <= 12'h12C;
    idle(6);
    chk("irq", 1, irq);
    chk("irq_req", 0, irq_req);
    wr(ADDR_IRQ_STAT, 32'h1);
    idle(2);
    chk("irq", 0, irq);
    rd(ADDR_IRQ_MASK, 32'h1);
    gie <= 1'b0;
    // capture route follows the comparator only when enabled
    wr(ADDR_CSR, 32'h04);
    idle(4);
    chk("route_en", 1, route_en);
    chk("cap_in", 1, cap_in);
    pos_mv <= 12'h064;
    idle(5);
    chk("cap_in", 0, cap_in);
    wr(ADDR_CSR, 32'h00);
    pos_mv <= 12'h12C;
    idle(5);
    chk("cap_in", 0, cap_in);
    // bandgap and power off; output bit ignores writes
    neg_mv <= 12'h190;
    wr(ADDR_CSR, 32'h20);
    idle(5);
    rd(ADDR_CSR, 32'h10);
    wr(ADDR_CSR, 32'h50);
    idle(5);
    chk("bg_sel", 1, bg_sel);
    rd(ADDR_CSR, 32'h70);
    wr(ADDR_CSR, 32'hD0);
    idle(5);
    chk("pwr_off", 1, pwr_off);
    rd(ADDR_CSR, 32'hD0);
    // random buffer disables and pin levels
    for (int i = 0; i < 6; i++) begin
      v = xs();
      pos_dig <= v[8];
      neg_dig <= v[9];
      wr(ADDR_DIG_DIS, v);
      idle(4);
      chk("dis", v[7:0], dis);
      chk("pin_rd", {v[9] & ~v[1], v[8] & ~v[0]}, pin_rd);
      rd(ADDR_DIG_DIS, v & 32'hFF);
    end
    // analog pins: buffers off, reads held at zero
    wr(ADDR_DIG_DIS, 32'h03);
    idle(4);
    chk("pin_rd", 0, pin_rd);
    // clock enable low holds ready low until it returns
    ce <= 1'b0;
    fork
      begin
        idle(3);
        chk("pready", 0, pready);
        ce <= 1'b1;
      end
      rd(ADDR_DIG_DIS, 32'h03);
    join
    idle(3);
    chk("pending", 0, expq.size());
    summarize();
  end
endmodule // testbench
